// ==== design/uiu_consts.svh ====
// constants of the interrupt unit: offsets, fields, reset values, timing
// assumes inclusion by bare name from the design file
`ifndef UIU_CONSTS_SVH
`define UIU_CONSTS_SVH
`define UIU_ADDR_GLOBAL_EN   8'h20
`define UIU_ADDR_EP_EN       8'h21
`define UIU_ADDR_DAC_EN      8'h22
`define UIU_ADDR_DAC_POL     8'h23
`define UIU_ADDR_PORT_EN     8'h26
`define UIU_ADDR_PORT_POL    8'h27
`define UIU_ADDR_PSCR        8'hFF
`define UIU_EN_RESET         8'h00
`define UIU_PSCR_PEND_BIT    7
`define UIU_PSCR_IE_BIT      2
`define UIU_GEN_BUSRST_BIT   0
`define UIU_GEN_T128_BIT     1
`define UIU_GEN_T1024_BIT    2
`define UIU_GEN_DAC_BIT      6
`define UIU_GEN_GPIO_BIT     7
`define UIU_VEC_RESET        16'h0000
`define UIU_VEC_STEP         16'h0002
`define UIU_VEC_BUSRST       16'h0002
`define UIU_VEC_DAC          16'h0014
`define UIU_VEC_GPIO         16'h0016
`define UIU_CALL_CYCLES      10
`define UIU_JMP_CYCLES       5
`define UIU_SE0_NS           8000
`define UIU_CLK_NS           5
`define UIU_SE0_CYCLES       ((`UIU_SE0_NS + `UIU_CLK_NS - 1) / `UIU_CLK_NS)
`endif

// ==== design/uiu_pkg.sv ====
// types of the interrupt unit
// assumes the constants header is alongside
package uiu_pkg;
    typedef enum logic [1:0] {
        UIU_IDLE,
        UIU_CALL,
        UIU_JUMP
    } uiu_state_e;
    typedef logic [3:0] uiu_src_t;
endpackage

// ==== design/uiu_irq_unit.sv ====
// interrupt unit of a small usb microcontroller core
// assumes core on same clock, strobes from core, pins unsynchronised
//
// Functional notes
// R1 - each source gated by its enable bit
// R2 - reset clears global and endpoint enables
// R3 - latches sampled on instruction last cycle
// R4 - ack: clear ie, clear latch, call vector
// R5 - call pushes pc, carry and zero flags
// R6 - return restores pc, flags, re-enables irqs
// R7 - enable instruction inside routine allows nesting
// R8 - reset starts at zero, two-byte vectors
// R9 - long se0 raises bus reset interrupt
// R10 - two timer tick interrupts, own vectors
// R11 - one interrupt per endpoint after packet
// R12 - latency: remaining plus call plus jump
// R13 - dac pins edge per polarity when enabled
// R14 - dac shares vector, blocks until pin idle
// R15 - no dac priority, enables kept on ack
// R16 - gpio pins, polarity per port, one vector
// R17 - gpio blocks until pin idle or disabled
// R18 - no pin priority, port enables kept
// R19 - firmware disables timers before suspend
// R20 - status bit 7 shows pending until ack
// R21 - status bit 2 mirrors ie, writes ignored
// R22 - lowest vector number wins
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "uiu_consts.svh"
module uiu_irq_unit #(
    parameter int DAC_PINS  = 8,
    parameter int GPIO_PINS = 32,
    parameter int SE0_CYC   = `UIU_SE0_CYCLES
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // core sequencing
    input  wire logic                 instr_last,
    input  wire logic                 ei_exec,
    input  wire logic                 di_exec,
    input  wire logic                 return_from_irq_instr_exec,
    input  wire logic                 core_carry,
    input  wire logic                 core_zero,
    input  wire logic [15:0]          core_pc,
    // stack handling, done by the core
    output logic                      push_req,
    output logic      [15:0]          push_pc,
    output logic                      push_carry,
    output logic                      push_zero,
    output logic                      restore_flags,
    output logic      [15:0]          fetch_addr,
    output logic                      fetch_load,
    output logic                      irq_active,
    // sources
    input  wire logic                 se0_pin,
    input  wire logic                 tick_128us,
    input  wire logic                 tick_1024us,
    input  wire logic [2:0]           ep_done,
    input  wire logic [DAC_PINS-1:0]  dac_pin,
    input  wire logic [GPIO_PINS-1:0] gpio_pin
);
    localparam int PORTS = GPIO_PINS / 8;
    localparam int NSRC  = 11;

    logic [7:0]            global_en;
    logic [7:0]            endpoint_irq_enable;
    logic [DAC_PINS-1:0]   dac_en;
    logic [DAC_PINS-1:0]   dac_pol;
    logic [PORTS-1:0]      port_en;
    logic [PORTS-1:0]      port_pol;
    logic                  ie;
    logic [NSRC:1]         latch;
    logic                  pend;
    uiu_pkg::uiu_state_e   state;
    logic [3:0]            cnt;
    uiu_pkg::uiu_src_t     sel;
    logic [15:0]           ret_pc;

    // three-stage sync for pins
    logic                  se0_s1, se0_s2, se0_s3;
    logic [DAC_PINS-1:0]   dac_s1, dac_s2, dac_s3;
    logic [GPIO_PINS-1:0]  gp_s1, gp_s2, gp_s3;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            se0_s1 <= 1'b0;
            se0_s2 <= 1'b0;
            se0_s3 <= 1'b0;
            dac_s1 <= '0;
            dac_s2 <= '0;
            dac_s3 <= '0;
            gp_s1  <= '0;
            gp_s2  <= '0;
            gp_s3  <= '0;
        end else begin
            se0_s1 <= se0_pin;
            se0_s2 <= se0_s1;
            se0_s3 <= se0_s2;
            dac_s1 <= dac_pin;
            dac_s2 <= dac_s1;
            dac_s3 <= dac_s2;
            gp_s1  <= gpio_pin;
            gp_s2  <= gp_s1;
            gp_s3  <= gp_s2;
        end
    end

    // stable levels: change counts when stages two and three agree
    logic                  se0_lv;
    logic [DAC_PINS-1:0]   dac_lv;
    logic [GPIO_PINS-1:0]  gp_lv;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            se0_lv <= 1'b0;
            dac_lv <= '0;
            gp_lv  <= '0;
        end else begin
            if (se0_s2 == se0_s3)
                se0_lv <= se0_s3;
            for (int i = 0; i < DAC_PINS; i++)
                if (dac_s2[i] == dac_s3[i])
                    dac_lv[i] <= dac_s3[i];
            for (int i = 0; i < GPIO_PINS; i++)
                if (gp_s2[i] == gp_s3[i])
                    gp_lv[i] <= gp_s3[i];
        end
    end

    // se0 duration counter
    logic [$clog2(SE0_CYC+2)-1:0] se0_cnt;
    logic                         bus_rst_ev;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            se0_cnt    <= '0;
            bus_rst_ev <= 1'b0;
        end else begin
            bus_rst_ev <= 1'b0;
            if (!se0_lv)
                se0_cnt <= '0;
            else if (se0_cnt <= SE0_CYC[$bits(se0_cnt)-1:0]) begin
                se0_cnt <= se0_cnt + 1'b1;
                // one event per se0, not repeated while held
                if (se0_cnt == SE0_CYC[$bits(se0_cnt)-1:0])
                    bus_rst_ev <= 1'b1; // [R9]
            end
        end
    end

    // pin edge detection with lockout
    function automatic logic active_lv(input logic v, input logic pol);
        return pol ? v : !v;
    endfunction

    logic [DAC_PINS-1:0]  dac_prev;
    logic [GPIO_PINS-1:0] gp_prev;
    logic                 dac_lock_on, gp_lock_on;
    int                   dac_lock, gp_lock;
    logic                 dac_ev, gp_ev;
    logic                 next_dac_ev, next_gp_ev;
    int                   next_dac_lock, next_gp_lock;
    logic                 next_dac_on, next_gp_on;

    always_comb begin
        next_dac_ev   = 1'b0;
        next_dac_lock = dac_lock;
        next_dac_on   = dac_lock_on;
        // lock releases when pin idle or disabled [R14]
        if (dac_lock_on && (!dac_en[dac_lock] ||
            !active_lv(dac_lv[dac_lock], dac_pol[dac_lock])))
            next_dac_on = 1'b0;
        // scan runs up from pin 0; on edges in one cycle the lowest pin wins [R15]
        for (int i = 0; i < DAC_PINS; i++)
            if (!next_dac_on && dac_en[i] &&
                active_lv(dac_lv[i], dac_pol[i]) &&
                !active_lv(dac_prev[i], dac_pol[i])) begin
                next_dac_ev   = 1'b1; // [R13]
                next_dac_on   = 1'b1;
                next_dac_lock = i;
            end
    end

    always_comb begin
        next_gp_ev   = 1'b0;
        next_gp_lock = gp_lock;
        next_gp_on   = gp_lock_on;
        if (gp_lock_on && (!port_en[gp_lock/8] ||
            !active_lv(gp_lv[gp_lock], port_pol[gp_lock/8])))
            next_gp_on = 1'b0; // [R17]
        for (int i = 0; i < GPIO_PINS; i++)
            if (!next_gp_on && port_en[i/8] &&
                active_lv(gp_lv[i], port_pol[i/8]) &&
                !active_lv(gp_prev[i], port_pol[i/8])) begin
                next_gp_ev   = 1'b1; // [R16] [R18]
                next_gp_on   = 1'b1;
                next_gp_lock = i;
            end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dac_prev    <= '0;
            gp_prev     <= '0;
            dac_lock_on <= 1'b0;
            gp_lock_on  <= 1'b0;
            dac_lock    <= 0;
            gp_lock     <= 0;
            dac_ev      <= 1'b0;
            gp_ev       <= 1'b0;
        end else begin
            dac_prev    <= dac_lv;
            gp_prev     <= gp_lv;
            dac_lock_on <= next_dac_on;
            gp_lock_on  <= next_gp_on;
            dac_lock    <= next_dac_lock;
            gp_lock     <= next_gp_lock;
            dac_ev      <= next_dac_ev;
            gp_ev       <= next_gp_ev;
        end
    end

    // source events by vector number; 7..9 reserved
    logic [NSRC:1] src_ev;
    always_comb begin
        src_ev     = '0;
        src_ev[1]  = bus_rst_ev;
        src_ev[2]  = tick_128us;    // [R10]
        src_ev[3]  = tick_1024us;
        src_ev[4]  = ep_done[0];    // [R11]
        src_ev[5]  = ep_done[1];
        src_ev[6]  = ep_done[2];
        src_ev[10] = dac_ev;
        src_ev[11] = gp_ev;
    end

    // enable gating per vector
    logic [NSRC:1] src_en;
    always_comb begin
        src_en     = '0;
        src_en[1]  = global_en[`UIU_GEN_BUSRST_BIT];
        src_en[2]  = global_en[`UIU_GEN_T128_BIT];
        src_en[3]  = global_en[`UIU_GEN_T1024_BIT];
        src_en[4]  = endpoint_irq_enable[0];
        src_en[5]  = endpoint_irq_enable[1];
        src_en[6]  = endpoint_irq_enable[2];
        src_en[10] = global_en[`UIU_GEN_DAC_BIT];
        src_en[11] = global_en[`UIU_GEN_GPIO_BIT];
    end

    // lowest pending enabled vector
    logic [NSRC:1]     req;
    uiu_pkg::uiu_src_t pick;
    always_comb begin
        req  = latch & src_en; // [R1]
        pick = '0;
        for (int v = NSRC; v >= 1; v--)
            if (req[v])
                pick = v[3:0]; // [R22]
    end

    wire take = (state == uiu_pkg::UIU_IDLE) && instr_last && ie &&
                (pick != '0); // [R3]

    // latches: a new event wins over the ack clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            latch <= '0;
        else
            for (int v = 1; v <= NSRC; v++)
                if (src_ev[v])
                    latch[v] <= 1'b1;
                else if (take && pick == v[3:0])
                    latch[v] <= 1'b0; // [R4]
    end

    // pending flag: set on recognition, cleared by ack
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            pend <= 1'b0;
        else if (take)
            pend <= 1'b0; // [R20]
        else if (ie && (req != '0))
            pend <= 1'b1; // [R20]
    end

    // interrupt enable of the core
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ie <= 1'b0;
        else if (take || di_exec)
            ie <= 1'b0; // [R4] [R21]
        else if (ei_exec)
            ie <= 1'b1; // [R7]
        else if (return_from_irq_instr_exec)
            ie <= 1'b1; // [R6]
    end

    // acknowledge sequence: call, then jump cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= uiu_pkg::UIU_IDLE;
            cnt   <= '0;
            sel   <= '0;
        end else begin
            unique case (state)
                uiu_pkg::UIU_IDLE: begin
                    if (take) begin
                        state <= uiu_pkg::UIU_CALL;
                        sel   <= pick;
                        cnt   <= 4'(`UIU_CALL_CYCLES - 1);
                    end
                end
                uiu_pkg::UIU_CALL: begin
                    if (cnt == '0) begin
                        state <= uiu_pkg::UIU_JUMP;
                        cnt   <= 4'(`UIU_JMP_CYCLES - 1); // [R12]
                    end else
                        cnt <= cnt - 1'b1;
                end
                uiu_pkg::UIU_JUMP: begin
                    if (cnt == '0)
                        state <= uiu_pkg::UIU_IDLE;
                    else
                        cnt <= cnt - 1'b1;
                end
            endcase
        end
    end

    // stack and vector outputs to the core
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            push_req      <= 1'b0;
            push_pc       <= '0;
            push_carry    <= 1'b0;
            push_zero     <= 1'b0;
            restore_flags <= 1'b0;
            fetch_addr    <= `UIU_VEC_RESET; // [R8]
            fetch_load    <= 1'b1;
            irq_active    <= 1'b0;
            ret_pc        <= '0;
        end else begin
            push_req      <= take;
            fetch_load    <= 1'b0;
            restore_flags <= return_from_irq_instr_exec; // [R6]
            irq_active    <= (state != uiu_pkg::UIU_IDLE) || take;
            if (take) begin
                push_pc    <= core_pc; // [R5]
                push_carry <= core_carry;
                push_zero  <= core_zero;
                ret_pc     <= core_pc;
            end
            // vector loads as the call completes; the jump follows
            if (state == uiu_pkg::UIU_CALL && cnt == '0) begin
                fetch_addr <= 16'(sel) * `UIU_VEC_STEP; // [R8]
                fetch_load <= 1'b1;
            end
        end
    end

    // register writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            global_en           <= `UIU_EN_RESET; // [R2]
            endpoint_irq_enable <= `UIU_EN_RESET; // [R2]
            dac_en              <= '0;
            dac_pol             <= '0;
            port_en             <= '0;
            port_pol            <= '0;
        end else if (reg_wr) begin
            // ack never touches these [R15] [R18]
            unique case (reg_addr)
                `UIU_ADDR_GLOBAL_EN: global_en <= reg_wdata;
                `UIU_ADDR_EP_EN:
                    endpoint_irq_enable <= {5'h00, reg_wdata[2:0]};
                `UIU_ADDR_DAC_EN:    dac_en <= reg_wdata[DAC_PINS-1:0];
                `UIU_ADDR_DAC_POL:   dac_pol <= reg_wdata[DAC_PINS-1:0];
                `UIU_ADDR_PORT_EN:   port_en <= reg_wdata[PORTS-1:0];
                `UIU_ADDR_PORT_POL:  port_pol <= reg_wdata[PORTS-1:0];
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd) begin
            unique case (reg_addr)
                `UIU_ADDR_GLOBAL_EN: reg_rdata <= global_en;
                `UIU_ADDR_EP_EN:     reg_rdata <= endpoint_irq_enable;
                `UIU_ADDR_DAC_EN:    reg_rdata <= 8'(dac_en);
                `UIU_ADDR_DAC_POL:   reg_rdata <= 8'(dac_pol);
                `UIU_ADDR_PORT_EN:   reg_rdata <= 8'(port_en);
                `UIU_ADDR_PORT_POL:  reg_rdata <= 8'(port_pol);
                `UIU_ADDR_PSCR:
                    reg_rdata <= {pend, 4'h0, ie, 2'h0}; // [R20] [R21]
                default:             reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end
endmodule

// ==== verif/uiu_irq_unit_chk.sv ====
// assertions on the interrupt unit ports
// assumes one clock domain, async active-high reset
`timescale 1ns/1ps
module uiu_irq_unit_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // core link
    input wire logic        instr_last,
    input wire logic        return_from_irq_instr_exec,
    input wire logic        core_carry,
    input wire logic        core_zero,
    input wire logic [15:0] core_pc,
    input wire logic        push_req,
    input wire logic [15:0] push_pc,
    input wire logic        push_carry,
    input wire logic        push_zero,
    input wire logic        restore_flags,
    input wire logic [15:0] fetch_addr,
    input wire logic        fetch_load,
    input wire logic        irq_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_take; push_req |-> $past(instr_last); endproperty
    a_take: assert property (p_take) else $error("take off end");
    property p_push; push_req |-> push_pc == $past(core_pc) &&
        push_carry == $past(core_carry) && push_zero == $past(core_zero);
    endproperty
    a_push: assert property (p_push) else $error("push state");
    property p_call; push_req |-> ##10 fetch_load; endproperty
    a_call: assert property (p_call) else $error("call length");
    property p_busy; push_req |-> irq_active [*8] ##1 irq_active [*8]
        ##1 !irq_active;
    endproperty
    a_busy: assert property (p_busy) else $error("latency");
    property p_once; push_req |=> !push_req [*8]; endproperty
    a_once: assert property (p_once) else $error("retake");
    property p_vec; fetch_load |-> fetch_addr inside {16'h0000, 16'h0002,
        16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h0014,
        16'h0016};
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_ret; return_from_irq_instr_exec |=> restore_flags; endproperty
    a_ret: assert property (p_ret) else $error("no restore");
    property p_rcause; restore_flags |-> $past(return_from_irq_instr_exec); endproperty
    a_rcause: assert property (p_rcause) else $error("stray restore");
    property p_epres; reg_rd && reg_addr == 8'h21 |=>
        reg_rdata[7:3] == 5'h00;
    endproperty
    a_epres: assert property (p_epres) else $error("ep reserved");
    property p_psres; reg_rd && reg_addr == 8'hFF |=>
        (reg_rdata & 8'h7B) == 8'h00;
    endproperty
    a_psres: assert property (p_psres) else $error("status bits");
endmodule

bind uiu_irq_unit uiu_irq_unit_chk u_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_last(instr_last), .return_from_irq_instr_exec(return_from_irq_instr_exec),
    .core_carry(core_carry), .core_zero(core_zero), .core_pc(core_pc),
    .push_req(push_req), .push_pc(push_pc), .push_carry(push_carry),
    .push_zero(push_zero), .restore_flags(restore_flags),
    .fetch_addr(fetch_addr), .fetch_load(fetch_load),
    .irq_active(irq_active)
);

// ==== verif/uiu_core_model.sv ====
// behavioural processor core facing the interrupt unit
// assumes same clock; bench asks for ei/di/return_from_irq_instr through cmd
`timescale 1ns/1ps
module uiu_core_model (
    // clock and reset
    input wire logic         clk,
    input wire logic         sys_rst,
    // bench control: hold instruction end, cmd bits ei/di/return_from_irq_instr
    input wire logic         stall,
    input wire logic [2:0]   cmd,
    // to the unit
    output logic             instr_last,
    output logic             ei_exec,
    output logic             di_exec,
    output logic             return_from_irq_instr_exec,
    output logic             core_carry,
    output logic             core_zero,
    output logic [15:0]      core_pc,
    // from the unit
    input wire logic         push_req,
    input wire logic [15:0]  push_pc,
    input wire logic         push_carry,
    input wire logic         push_zero,
    input wire logic         restore_flags,
    input wire logic [15:0]  fetch_addr,
    input wire logic         fetch_load
);
    logic [2:0]  cnt;
    logic [2:0]  len;
    logic [17:0] stk[$];
    logic [17:0] top;
    // lengths cycle 1..5 so every remaining count is met
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 3'h1;
            len <= 3'h1;
            instr_last <= 1'b0;
            {ei_exec, di_exec, return_from_irq_instr_exec} <= 3'h0;
            core_pc <= 16'h0000;
            stk.delete();
        end else begin
            {return_from_irq_instr_exec, di_exec, ei_exec} <= cmd;
            instr_last <= !stall && cnt == 3'h1;
            if (!stall && cnt == 3'h1) begin
                len <= (len == 3'h5) ? 3'h1 : len + 3'h1;
                cnt <= len;
            end else if (!stall) begin
                cnt <= cnt - 3'h1;
            end
            if (push_req) begin
                stk.push_back({push_pc, push_carry, push_zero});
            end
            if (fetch_load) begin
                core_pc <= fetch_addr;
            end else if (restore_flags && stk.size() > 0) begin
                top = stk.pop_back();
                core_pc <= top[17:2];
            end else if (instr_last) begin
                core_pc <= core_pc + 16'h0001;
            end
        end
    end
    // flags follow pc bits 0 and 1 so pushes carry pairs that vary with pc
    assign core_carry = core_pc[0];
    assign core_zero  = core_pc[1];
endmodule

// ==== verif/uiu_irq_unit_tb.sv ====
// self-checking bench of the interrupt unit with a core model
// assumes design, checker and core model compiled before this file
`timescale 1ns/1ps
module uiu_irq_unit_tb;
    logic        clk, sys_rst, reg_wr, reg_rd, stall, se0_pin;
    logic        tick_128us, tick_1024us, armed;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, dac_pin, r;
    logic [2:0]  ep_done, cmd;
    logic [31:0] gpio_pin;
    logic        instr_last, ei_exec, di_exec, return_from_irq_instr_exec, core_carry;
    logic        core_zero, push_req, push_carry, push_zero, restore_flags;
    logic        fetch_load, irq_active;
    logic [15:0] core_pc, push_pc, fetch_addr;
    logic [15:0] exp_q[$];
    int          err_count, check_count, cyc, k, j, p, b;

    uiu_irq_unit #(.SE0_CYC(8)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_last(instr_last),
        .ei_exec(ei_exec), .di_exec(di_exec), .return_from_irq_instr_exec(return_from_irq_instr_exec),
        .core_carry(core_carry), .core_zero(core_zero), .core_pc(core_pc),
        .push_req(push_req), .push_pc(push_pc), .push_carry(push_carry),
        .push_zero(push_zero), .restore_flags(restore_flags),
        .fetch_addr(fetch_addr), .fetch_load(fetch_load),
        .irq_active(irq_active), .se0_pin(se0_pin),
        .tick_128us(tick_128us), .tick_1024us(tick_1024us),
        .ep_done(ep_done), .dac_pin(dac_pin), .gpio_pin(gpio_pin));
    uiu_core_model u_core (.clk(clk), .sys_rst(sys_rst), .stall(stall),
        .cmd(cmd), .instr_last(instr_last), .ei_exec(ei_exec),
        .di_exec(di_exec), .return_from_irq_instr_exec(return_from_irq_instr_exec), .core_carry(core_carry),
        .core_zero(core_zero), .core_pc(core_pc), .push_req(push_req),
        .push_pc(push_pc), .push_carry(push_carry), .push_zero(push_zero),
        .restore_flags(restore_flags), .fetch_addr(fetch_addr),
        .fetch_load(fetch_load));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk8(reg_rdata, e);
    endtask
    task automatic pulse(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
    endtask
    // bounded wait through each of n services, then the routine's last command after each
    task automatic serve(input int n, input logic [2:0] c);
        int i;
        repeat (n) begin
            i = 0;
            while (irq_active !== 1'b1 && i < 300) begin
                @(posedge clk);
                i++;
            end
            while (irq_active !== 1'b0 && i < 300) begin
                @(posedge clk);
                i++;
            end
            pulse(c);
        end
    endtask

    // the expected queue is the reference: any unplanned vector fails
    always @(posedge clk) begin
        if (armed && fetch_load === 1'b1) begin
            if (exp_q.size() == 0) chk16(fetch_addr, 16'hFFFF);
            else chk16(fetch_addr, exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        {sys_rst, reg_wr, reg_rd, stall, se0_pin, armed} = 6'h20;
        {tick_128us, tick_1024us, reg_addr, reg_wdata} = 18'h00000;
        {ep_done, cmd, dac_pin, gpio_pin} = 46'h0;
        r = 8'($urandom(83));
        idle(16);
        sys_rst <= 1'b0;
        idle(2);
        armed = 1'b1;
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'hFF, 8'h00);
        r = 8'($urandom);
        wr(8'h21, r);
        rd(8'h21, r & 8'h07);
        rd(8'h30, 8'h00);
        wr(8'h20, 8'h06);
        wr(8'h21, 8'h07);
        {tick_128us, tick_1024us, ep_done} <= 5'h1F;
        @(posedge clk);
        {tick_128us, tick_1024us, ep_done} <= 5'h00;
        exp_q = '{16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C};
        pulse(3'h1);
        serve(1, 3'h1);
        serve(4, 3'h4);
        pulse(3'h4);
        wr(8'h21, 8'h01);
        ep_done <= {1'($urandom), 2'b10};
        @(posedge clk);
        ep_done <= 3'h0;
        idle(40);
        stall <= 1'b1;
        ep_done <= 3'h1;
        @(posedge clk);
        ep_done <= 3'h0;
        idle(8);
        rd(8'hFF, 8'h84);
        wr(8'hFF, 8'h00);
        rd(8'hFF, 8'h84);
        exp_q.push_back(16'h0008);
        stall <= 1'b0;
        serve(1, 3'h2);
        rd(8'hFF, 8'h00);
        pulse(3'h4);
        rd(8'hFF, 8'h04);
        wr(8'h20, 8'h01);
        se0_pin <= 1'b1;
        idle(4);
        se0_pin <= 1'b0;
        idle(30);
        exp_q.push_back(16'h0002);
        se0_pin <= 1'b1;
        serve(1, 3'h4);
        se0_pin <= 1'b0;
        k = $urandom % 8;
        j = (k + 1) % 8;
        wr(8'h20, 8'h40);
        wr(8'h22, 8'((1 << k) | (1 << j)));
        wr(8'h23, 8'hFF);
        exp_q.push_back(16'h0014);
        dac_pin[k] <= 1'b1;
        serve(1, 3'h4);
        dac_pin[j] <= 1'b1;
        idle(40);
        dac_pin <= 8'h00;
        wr(8'h23, 8'h00);
        dac_pin[j] <= 1'b1;
        idle(10);
        exp_q.push_back(16'h0014);
        dac_pin[j] <= 1'b0;
        serve(1, 3'h4);
        rd(8'h22, 8'((1 << k) | (1 << j)));
        p = $urandom % 4;
        b = $urandom % 8;
        wr(8'h20, 8'h80);
        wr(8'h26, 8'(1 << p));
        wr(8'h27, 8'(1 << p));
        exp_q.push_back(16'h0016);
        gpio_pin[p * 8 + b] <= 1'b1;
        serve(1, 3'h4);
        gpio_pin[p * 8 + (b + 1) % 8] <= 1'b1;
        idle(40);
        rd(8'h26, 8'(1 << p));
        chk16(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule
